//--- hw/dram_ctrl_defines.svh
// Timing, geometry and count constants for the page/refresh memory controller
`ifndef DRAM_CTRL_DEFINES_SVH
`define DRAM_CTRL_DEFINES_SVH

`define CLK_PERIOD_NS      50
`define ADDR_BITS          7
`define ROW_COUNT          128
`define PAGE_MAX_COLS      128
`define CHIP_COUNT         4
`define CHIP_SEL_BITS      2
`define INIT_REFRESH_COUNT 8
`define REFRESH_PERIOD_NS  2000000
`define T_RP_NS            100
`define T_RAH_NS           50
`define T_RAS_NS           200
`define T_CAC_NS           150
`define SYNC_STAGES        2
`define WAIT_BITS          8
`define PAGE_CNT_BITS      8
`define INIT_CNT_BITS      4

`endif

//--- hw/dram_ctrl_pkg.sv
// Types and helper arithmetic for the page/refresh memory controller
`include "dram_ctrl_defines.svh"

package dram_ctrl_pkg;

	typedef enum logic [3:0] {
		ST_IDLE,
		ST_ROW_SETUP,
		ST_ROW_HOLD,
		ST_REF_HOLD,
		ST_COL_SETUP,
		ST_CAS_LOW,
		ST_CAS_HIGH,
		ST_PRECHARGE,
		ST_FAULT
	} ctrl_state_e;

	typedef struct packed {
		ctrl_state_e                 st;
		logic [`WAIT_BITS-1:0]       wait_cnt;
		logic                        ras_n;
		logic [`CHIP_COUNT-1:0]      cas_n;
		logic                        we_n;
		logic [`ADDR_BITS-1:0]       addr;
		logic                        din;
		logic [`ADDR_BITS-1:0]       row;
		logic [`CHIP_SEL_BITS-1:0]   chip;
		logic                        write;
		logic                        is_refresh;
		logic [`ADDR_BITS-1:0]       refresh_row;
		logic [`INIT_CNT_BITS-1:0]   init_cnt;
		logic                        ref_pend;
		logic [`PAGE_CNT_BITS-1:0]   page_cnt;
		logic                        rdata;
		logic                        resp_valid;
		logic                        dout_meta;
		logic                        dout_sync;
		logic                        fault_meta;
		logic                        fault_sync;
	} ctrl_s;

	typedef struct packed {
		logic [31:0] count;
		logic        tick;
	} timer_s;

	// Least time in ns to whole clock cycles, never below one
	function automatic logic [7:0] ns_to_cycles(input int unsigned ns);
		int unsigned c;
		c = (ns + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS;
		if (c == 0)
		begin
			c = 1;
		end
		return c[7:0];
	endfunction : ns_to_cycles

endpackage : dram_ctrl_pkg

//--- hw/refresh_interval_timer.sv
// Periodic refresh request timer: one-cycle tick every interval
module refresh_interval_timer
	import dram_ctrl_pkg::*;
#(
	parameter int unsigned INTERVAL_CYCLES = 312
)
(
	input  wire logic clk_sys,
	input  wire logic resetn,
	output logic      tick
);

	timer_s t_reg;
	timer_s t_next;

	always_comb
	begin
		t_next      = t_reg;
		t_next.tick = 1'b0;
		if (t_reg.count >= INTERVAL_CYCLES - 1)
		begin
			t_next.count = 32'h0000_0000;
			t_next.tick  = 1'b1;
		end
		else
		begin
			t_next.count = t_reg.count + 32'h0000_0001;
		end
	end

	always_ff @(posedge clk_sys or negedge resetn)
	begin
		if (!resetn)
		begin
			t_reg <= '0;
		end
		else
		begin
			t_reg <= t_next;
		end
	end

	assign tick = t_reg.tick;

endmodule : refresh_interval_timer

//--- hw/dram_page_refresh_control.sv
// Host-side controller: page access, strobe-only refresh, init, fault guard
`include "dram_ctrl_defines.svh"

// Overview of operation
// - Latch row once, keep row strobe low, run successive column cycles.
// - A page never exceeds 128 column accesses under one open row.
// - Row strobe goes to all chips; column strobe decoded per chip.
// - All 128 rows must be cycled within every 2 ms.
// - Decoded row strobe as chip select is preferred for lowest power; here the row strobe goes to all chips.
// - At least 8 refresh cycles after power-up before normal accesses.
// - On supply fault, force row and column strobes inactive high.
// - Row bits on row strobe fall, column bits on column strobe fall.
module dram_page_refresh_control
	import dram_ctrl_pkg::*;
#(
	parameter int unsigned REFRESH_PERIOD_CYCLES =
		`REFRESH_PERIOD_NS / `CLK_PERIOD_NS
)
(
	input  wire logic                      clk_sys,
	input  wire logic                      resetn,
	input  wire logic                      req_valid,
	output logic                           req_ready,
	input  wire logic                      req_write,
	input  wire logic [`ADDR_BITS-1:0]     req_row,
	input  wire logic [`ADDR_BITS-1:0]     req_col,
	input  wire logic [`CHIP_SEL_BITS-1:0] req_chip,
	input  wire logic                      req_wdata,
	output logic                           resp_valid,
	output logic                           resp_rdata,
	output logic                           init_done,
	input  wire logic                      supply_fault,
	output logic                           ras_n,
	output logic [`CHIP_COUNT-1:0]         cas_n,
	output logic                           we_n,
	output logic [`ADDR_BITS-1:0]          muxed_address_lines,
	output logic                           mem_din,
	input  wire logic                      mem_dout
);

	////////////////////////////////////////////////////////////////////////
	// Timing counts

	localparam logic [7:0] RP_CYC  = ns_to_cycles(`T_RP_NS);
	localparam logic [7:0] RAH_CYC = ns_to_cycles(`T_RAH_NS);
	localparam logic [7:0] RAS_CYC = ns_to_cycles(`T_RAS_NS);
	localparam logic [7:0] CAS_CYC = 8'(ns_to_cycles(`T_CAC_NS)
		+ 8'(`SYNC_STAGES));
	localparam int unsigned INTERVAL_CYCLES =
		REFRESH_PERIOD_CYCLES / `ROW_COUNT;

	////////////////////////////////////////////////////////////////////////
	// Refresh timer

	logic ref_tick;

	refresh_interval_timer #(
		.INTERVAL_CYCLES (INTERVAL_CYCLES)
	) u_timer (
		.clk_sys (clk_sys),
		.resetn  (resetn),
		.tick    (ref_tick)
	);

	////////////////////////////////////////////////////////////////////////
	// Controller state

	ctrl_s s_reg;
	ctrl_s s_next;
	logic  init_ok;
	logic  page_ok;

	assign init_ok = (s_reg.init_cnt >= `INIT_CNT_BITS'(`INIT_REFRESH_COUNT));
	assign page_ok = (s_reg.page_cnt < `PAGE_CNT_BITS'(`PAGE_MAX_COLS))
		&& (req_row == s_reg.row);

	// Refresh and init win over user requests
	always_comb
	begin
		req_ready = 1'b0;
		if (!s_reg.fault_sync && init_ok && !s_reg.ref_pend)
		begin
			if (s_reg.st == ST_IDLE)
			begin
				req_ready = 1'b1;
			end
			else if (s_reg.st == ST_CAS_HIGH && page_ok)
			begin
				req_ready = 1'b1;
			end
		end
	end

	always_comb
	begin
		s_next            = s_reg;
		s_next.resp_valid = 1'b0;
		s_next.dout_meta  = mem_dout;
		s_next.dout_sync  = s_reg.dout_meta;
		s_next.fault_meta = supply_fault;
		s_next.fault_sync = s_reg.fault_meta;
		if (ref_tick)
		begin
			s_next.ref_pend = 1'b1;
		end
		if (s_reg.wait_cnt != '0)
		begin
			s_next.wait_cnt = s_reg.wait_cnt - 8'h01;
		end
		if (s_reg.fault_sync)
		begin
			s_next.ras_n    = 1'b1;
			s_next.cas_n    = '1;
			s_next.we_n     = 1'b1;
			s_next.st       = ST_FAULT;
		end
		else
		begin
			case (s_reg.st)
				ST_IDLE:
				begin
					s_next.page_cnt = '0;
					if (s_reg.ref_pend || !init_ok)
					begin
						s_next.is_refresh = 1'b1;
						s_next.addr       = s_reg.refresh_row;
						s_next.st         = ST_ROW_SETUP;
					end
					else if (req_valid)
					begin
						s_next.is_refresh = 1'b0;
						s_next.addr       = req_row;
						s_next.row        = req_row;
						s_next.st         = ST_ROW_SETUP;
					end
				end
				ST_ROW_SETUP:
				begin
					s_next.ras_n = 1'b0;
					if (s_reg.is_refresh)
					begin
						s_next.wait_cnt = RAS_CYC;
						s_next.st       = ST_REF_HOLD;
					end
					else
					begin
						s_next.wait_cnt = RAH_CYC;
						s_next.st       = ST_ROW_HOLD;
					end
				end
				ST_REF_HOLD:
				begin
					if (s_reg.wait_cnt <= 8'h01)
					begin
						s_next.ras_n       = 1'b1;
						s_next.refresh_row = s_reg.refresh_row + 7'h01;
						s_next.ref_pend    = ref_tick;
						if (!init_ok)
						begin
							s_next.init_cnt = s_reg.init_cnt + 4'h1;
						end
						s_next.wait_cnt = RP_CYC;
						s_next.st       = ST_PRECHARGE;
					end
				end
				ST_ROW_HOLD:
				begin
					if (s_reg.wait_cnt <= 8'h01)
					begin
						s_next.st = ST_CAS_HIGH;
					end
				end
				ST_COL_SETUP:
				begin
					s_next.cas_n[s_reg.chip] = 1'b0;
					s_next.page_cnt = s_reg.page_cnt + 8'h01;
					s_next.wait_cnt = CAS_CYC;
					s_next.st       = ST_CAS_LOW;
				end
				ST_CAS_LOW:
				begin
					if (s_reg.wait_cnt <= 8'h01)
					begin
						if (!s_reg.write)
						begin
							s_next.rdata = s_reg.dout_sync;
						end
						s_next.resp_valid = 1'b1;
						s_next.cas_n      = '1;
						s_next.we_n       = 1'b1;
						s_next.st         = ST_CAS_HIGH;
					end
				end
				ST_CAS_HIGH:
				begin
					if (req_valid && req_ready)
					begin
						s_next.addr  = req_col;
						s_next.chip  = req_chip;
						s_next.write = req_write;
						s_next.din   = req_wdata;
						s_next.we_n  = !req_write;
						s_next.st    = ST_COL_SETUP;
					end
					else if (s_reg.page_cnt != '0 || s_reg.ref_pend)
					begin
						s_next.ras_n    = 1'b1;
						s_next.wait_cnt = RP_CYC;
						s_next.st       = ST_PRECHARGE;
					end
				end
				ST_PRECHARGE:
				begin
					if (s_reg.wait_cnt <= 8'h01)
					begin
						s_next.st = ST_IDLE;
					end
				end
				ST_FAULT:
				begin
					s_next.wait_cnt = RP_CYC;
					s_next.st       = ST_PRECHARGE;
				end
				default:
				begin
					s_next.st = ST_IDLE;
				end
			endcase
		end
	end

	// First access of a row waits in ST_CAS_HIGH with page_cnt zero
	always_ff @(posedge clk_sys or negedge resetn)
	begin
		if (!resetn)
		begin
			s_reg            <= '0;
			s_reg.st         <= ST_IDLE;
			s_reg.ras_n      <= 1'b1;
			s_reg.cas_n      <= '1;
			s_reg.we_n       <= 1'b1;
		end
		else
		begin
			s_reg <= s_next;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Outputs

	assign resp_valid          = s_reg.resp_valid;
	assign resp_rdata          = s_reg.rdata;
	assign init_done           = init_ok;
	assign ras_n               = s_reg.ras_n;
	assign cas_n               = s_reg.cas_n;
	assign we_n                = s_reg.we_n;
	assign muxed_address_lines = s_reg.addr;
	assign mem_din             = s_reg.din;

endmodule : dram_page_refresh_control

//--- test/dram_ctrl_props.sv
// Concurrent checks on the controller strobes and handshake
`include "dram_ctrl_defines.svh"
module dram_ctrl_props
#(
	parameter int unsigned REFRESH_PERIOD_CYCLES = 40000
)
(
	input wire logic			clk_sys,
	input wire logic			resetn,
	input wire logic			req_ready,
	input wire logic			resp_valid,
	input wire logic			init_done,
	input wire logic			supply_fault,
	input wire logic			ras_n,
	input wire logic [`CHIP_COUNT-1:0]	cas_n
);
	timeunit 1ns;
	timeprecision 1ns;
	localparam int unsigned GAP_MAX = REFRESH_PERIOD_CYCLES / 128 + 32;
	logic [7:0]		page_reg;
	logic [15:0]	gap_reg;
	logic			prev_reg;
	default clocking @(posedge clk_sys);
	endclocking
	default disable iff (!resetn);
	////////////////////////////////////////////////////////////////////
	// Column accesses per open row and cycles since the last row strobe
	always_ff @(posedge clk_sys or negedge resetn)
	begin
		if (!resetn)
		begin
			page_reg <= 8'h00;
			gap_reg <= 16'h0000;
			prev_reg <= 1'b1;
		end
		else
		begin
			page_reg <= ras_n ? 8'h00 : page_reg + {7'h00, resp_valid};
			gap_reg <= (prev_reg && !ras_n) || supply_fault || !init_done
				? 16'h0000 : gap_reg + 16'h0001;
			prev_reg <= ras_n;
		end
	end
	////////////////////////////////////////////////////////////////////
	fault_strobes_a: assert property (supply_fault [*4] |-> ras_n && &cas_n)
		else $error("strobes not high under fault");
	cas_onehot_a: assert property ($onehot0(~cas_n))
		else $error("more than one column strobe low");
	cas_ras_a: assert property (!(&cas_n) |-> !ras_n)
		else $error("column strobe without row strobe");
	ready_init_a: assert property (req_ready |-> init_done)
		else $error("request accepted before startup refresh");
	init_no_cas_a: assert property (!init_done |-> &cas_n)
		else $error("column strobe during startup refresh");
	cas_pulse_a: assert property (disable iff (!resetn || supply_fault)
		!(&cas_n) && &$past(cas_n) |-> !(&cas_n) [*5] ##1 (&cas_n && resp_valid))
		else $error("column strobe pulse or response misplaced");
	page_max_a: assert property (page_reg <= 8'h80)
		else $error("page longer than one row of columns");
	refresh_gap_a: assert property (gap_reg <= GAP_MAX)
		else $error("row strobe gap exceeds refresh interval");
endmodule : dram_ctrl_props

bind dram_page_refresh_control dram_ctrl_props
	#(.REFRESH_PERIOD_CYCLES(REFRESH_PERIOD_CYCLES)) props_inst
	(.clk_sys, .resetn, .req_ready, .resp_valid, .init_done,
	.supply_fault, .ras_n, .cas_n);

//--- test/dram_cell_model.sv
// Behavioural model of four one-bit dynamic memory chips
module dram_cell_model
(
	input wire logic		clk_sys,
	input wire logic		ras_n,
	input wire logic [3:0]	cas_n,
	input wire logic		we_n,
	input wire logic [6:0]	addr,
	input wire logic		din,
	output logic			dout
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [6:0]	row;
	logic [3:0]	drv;
	logic [3:0]	bitv;
	logic		tog = 1'b0;
	always @(posedge clk_sys)
		tog <= ~tog;
	always @(negedge ras_n)
		row <= addr;
	for (genvar i = 0; i < 4; i++)
	begin : g_chip
		logic		m [0:16383];
		logic [6:0]	col;
		logic		rd = 1'b0;
		always @(negedge cas_n[i])
		begin
			rd = we_n && !ras_n;
			if (!ras_n)
			begin
				col = addr;
				if (!we_n)
					m[{row, addr}] = din;
			end
		end
		assign drv[i] = !cas_n[i] && rd;
		assign bitv[i] = m[{row, col}];
	end
	assign dout = |drv ? |(drv & bitv) : tog;
endmodule : dram_cell_model

//--- test/tb_top.sv
// Self-checking bench for the page and refresh memory controller
`include "dram_ctrl_defines.svh"
module tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int unsigned PERIOD = 3840;
	logic clk_sys = 0, resetn = 0, req_valid = 0, req_write = 0;
	logic req_wdata = 0, supply_fault = 0, mem_dout;
	logic [`ADDR_BITS-1:0] req_row = 0, req_col = 0, muxed_address_lines;
	logic [`CHIP_SEL_BITS-1:0] req_chip = 0;
	logic req_ready, resp_valid, resp_rdata, init_done, ras_n, we_n, mem_din;
	logic [`CHIP_COUNT-1:0] cas_n;
	int err_total = 0, comparisons = 0, cycles = 0;
	dram_page_refresh_control #(.REFRESH_PERIOD_CYCLES(PERIOD))
	dram_page_refresh_control_inst (.clk_sys, .resetn, .req_valid,
		.req_ready, .req_write, .req_row, .req_col, .req_chip, .req_wdata,
		.resp_valid, .resp_rdata, .init_done, .supply_fault, .ras_n,
		.cas_n, .we_n, .muxed_address_lines, .mem_din, .mem_dout);
	dram_cell_model dram_cell_model_inst (.clk_sys, .ras_n, .cas_n, .we_n,
		.addr(muxed_address_lines), .din(mem_din), .dout(mem_dout));
	////////////////////////////////////////////////////////////////////
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		comparisons++;
		if (got !== exp)
		begin
			err_total++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic give_verdict;
		$display("errors %0d comparisons %0d", err_total, comparisons);
		if (err_total == 0 && comparisons > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : give_verdict
	task automatic do_req(input logic w, input logic [6:0] r, c,
		input logic [1:0] ch, input logic d, output logic q);
		int i;
		{req_write, req_row, req_col, req_chip, req_wdata} = {w, r, c, ch, d};
		req_valid = 1;
		#1;
		for (i = 0; i < 300 && !(req_ready === 1 && ras_n === 0); i++)
		begin
			@(negedge clk_sys);
			#1;
		end
		@(negedge clk_sys);
		req_valid = 0;
		for (i = 0; i < 20 && resp_valid !== 1; i++)
			@(negedge clk_sys);
		chk(i < 20, 1);
		q = resp_rdata;
	endtask : do_req
	////////////////////////////////////////////////////////////////////
	task automatic t_reset;
		int n;
		logic p;
		n = 0;
		p = 1;
		repeat (6) @(negedge clk_sys);
		chk({ras_n, cas_n, we_n, init_done, req_ready}, 8'hFC);
		resetn = 1;
		for (int i = 0; i < 300 && init_done !== 1; i++)
		begin
			@(negedge clk_sys);
			n += p && ras_n === 0;
			p = ras_n;
		end
		chk(n >= 8, 1);
		chk(init_done, 1);
	endtask : t_reset
	task automatic t_chips;
		logic q;
		logic [2:0] j;
		for (int k = 0; k < 16; k++)
		begin
			j = k[2:0];
			do_req(k < 8, j[2] ? 7'h64 : 7'h05, j[2] ? 7'h7F : 7'h00,
				j[1:0], j[0] ^ j[2], q);
			if (k >= 8)
				chk(q, j[0] ^ j[2]);
		end
	endtask : t_chips
	task automatic t_refresh;
		int n;
		logic p, c;
		n = 0;
		p = 1;
		c = 0;
		repeat (PERIOD + 40)
		begin
			@(negedge clk_sys);
			n += p && ras_n === 0;
			c |= cas_n !== 4'hF;
			p = ras_n;
		end
		chk(n >= 128, 1);
		chk(c, 0);
	endtask : t_refresh
	task automatic t_fault;
		logic q;
		req_write = 0;
		req_valid = 1;
		repeat (3) @(negedge clk_sys);
		supply_fault = 1;
		repeat (4) @(negedge clk_sys);
		req_valid = 0;
		chk({ras_n, cas_n, req_ready}, 8'h3E);
		supply_fault = 0;
		repeat (6) @(negedge clk_sys);
		do_req(0, 7'h05, 7'h00, 2'h1, 0, q);
		chk(q, 1);
	endtask : t_fault
	////////////////////////////////////////////////////////////////////
	initial
	begin
		forever #25 clk_sys = ~clk_sys;
	end
	always @(posedge clk_sys)
	begin
		cycles++;
		if (cycles == 20000)
		begin
			err_total++;
			give_verdict();
		end
	end
	initial
	begin
		t_reset();
		t_chips();
		t_refresh();
		t_fault();
		give_verdict();
	end
endmodule : tb_top
